// ===== design/sledc_pkg.sv
// shared constants for the front-panel status indicator block
// assumes a single 20 MHz system clock and an AHB-Lite register port
package sledc_pkg;

  // ****************************************************************
  // clock and flash timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;           // 20 MHz system clock
  localparam int TICK_NS       = 62_500_000;   // one flash time slot
  // whole cycles per time slot, at least one
  localparam int TICK_CYCLES   = (TICK_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                 (TICK_NS / CLK_PERIOD_NS);

  // bit of the free slot counter that gives each flash rate
  localparam int FAST_BIT      = 0;  // toggles every 62.5 ms: 8 per second
  localparam int SLOW_BIT      = 1;  // toggles every 125 ms: 4 per second
  localparam int CONST_BIT     = 2;  // boot and watchdog patterns
  localparam int PHASE_W       = 3;

  // power-up code blinking, in slots
  localparam logic [5:0] CODE_ON_SLOTS    = 6'h04;
  localparam logic [5:0] CODE_OFF_SLOTS   = 6'h04;
  localparam logic [5:0] CODE_PAUSE_SLOTS = 6'h10;
  localparam logic [5:0] CODE_GAP_SLOTS   = 6'h20;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATE      = 8'h04;
  localparam logic [7:0] ADDR_MOD_FAULT  = 8'h08;
  localparam logic [7:0] ADDR_AXIS_FAULT = 8'h0c; // four words, 0x0c..0x18
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h20;

  // control register fields
  localparam int CTRL_CFG_BIT   = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_W         = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // interrupt status fields
  localparam int IRQ_STATUS_ERR = 0;
  localparam int IRQ_STOP_ERR   = 1;
  localparam int IRQ_WATCHDOG   = 2;
  localparam int IRQ_DIAG_FAIL  = 3;
  localparam int IRQ_W          = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  localparam int FAULT_W   = 16;
  localparam int AXES      = 4;
  localparam int DIAG_W    = 4;
  localparam logic [15:0] FAULT_RESET = 16'h0000;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [2:0] {
    SLEDC_CODE_IDLE,
    SLEDC_CODE_ON,
    SLEDC_CODE_OFF,
    SLEDC_CODE_PAUSE,
    SLEDC_CODE_GAP
  } sledc_code_state_type;

endpackage : sledc_pkg

// ===== design/sledc_tick.sv
// slot divider: one-cycle enable every TICKS system clocks
// assumes hclk is the only clock; all slower rates derive from this pulse
`timescale 1ns/10ps
`default_nettype none

module sledc_tick #(
  parameter int TICKS = sledc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // slot enable
  output logic      tick
);

  localparam int CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

  logic [CW-1:0] count;

  // free-running divider, pulse on wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule : sledc_tick

`default_nettype wire

// ===== design/sledc_top.sv
// front-panel status indicator control with ahb-lite registers
// assumes error, mode and drive-enable inputs are synchronous to hclk
//
// What this block does
// - health steady normally, flashing on errors
// - status-only errors flash health four per second
// - servo-stop errors flash health eight per second
// - signalled error sets fault flag, loads code
// - boot mode: health and config flash together
// - watchdog: health and config flash alternately
// - power-up failure blinks two codes, config dark
// - liveness steadily lit while functioning
// - unfinished power-up leaves health, liveness dark
// - config lit once configuration received
// - four drive-enable lights follow relay outputs
// - clear pulse ends error unless cause persists
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module sledc_top #(
  parameter int TICK_CYCLES = sledc_pkg::TICK_CYCLES,
  parameter int AXES        = sledc_pkg::AXES
) (
  // clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // ahb-lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  // module state
  input  wire logic                           powerup_done,
  input  wire logic                           diag_fail,
  input  wire logic [sledc_pkg::DIAG_W-1:0]   diag_code_first,
  input  wire logic [sledc_pkg::DIAG_W-1:0]   diag_code_second,
  input  wire logic                           boot_mode,
  input  wire logic                           watchdog_timeout,
  // error reports
  input  wire logic                           err_report,
  input  wire logic                           err_stop,
  input  wire logic [2:0]                     err_axis,
  input  wire logic [sledc_pkg::FAULT_W-1:0]  err_code,
  input  wire logic                           err_persist,
  // drive-enable relay outputs
  input  wire logic [AXES-1:0]                drive_relay_on,
  // indicators
  output logic                                health_indicator,
  output logic                                liveness_indicator,
  output logic                                config_indicator,
  output logic                                axis1_drive_on_indicator,
  output logic                                axis2_drive_on_indicator,
  output logic                                axis3_drive_on_indicator,
  output logic                                axis4_drive_on_indicator,
  output logic                                module_fault,
  output logic                                irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int FW = sledc_pkg::FAULT_W;

  logic                               tick;
  logic [sledc_pkg::PHASE_W-1:0]      phase;
  logic [sledc_pkg::CTRL_W-1:0]       ctrl;
  logic                               clear_prev;
  logic                               clear_pulse;
  logic                               status_err;
  logic                               stop_err;
  logic [FW-1:0]                      mod_fault_word;
  logic [FW-1:0]                      axis_fault_word [AXES];
  logic [sledc_pkg::IRQ_W-1:0]        irq_status;
  logic [sledc_pkg::IRQ_W-1:0]        irq_mask;
  logic [sledc_pkg::IRQ_W-1:0]        irq_event;
  logic                               watchdog_prev;
  logic                               diag_prev;
  logic                               dp_write;
  logic [7:0]                         dp_addr;
  logic                               ap_valid;
  logic                               ap_read_status;
  logic                               running;
  logic                               code_lamp;
  logic                               next_health;
  logic                               next_config;
  sledc_pkg::sledc_code_state_type    code_state;
  logic [5:0]                         code_slots;
  logic [sledc_pkg::DIAG_W-1:0]       code_left;
  logic                               code_second;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // word index of a register byte address, shared by decode paths
  function automatic logic [5:0] word_of(input logic [7:0] a);
    word_of = a[7:2];
  endfunction : word_of

  // read mux; axis words sit at consecutive addresses
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (word_of(a) == word_of(sledc_pkg::ADDR_CTRL)) begin
      r[sledc_pkg::CTRL_W-1:0] = ctrl;
    end else if (word_of(a) == word_of(sledc_pkg::ADDR_STATE)) begin
      r[7:0] = {irq, module_fault, stop_err, status_err,
                config_indicator, liveness_indicator, health_indicator,
                running};
    end else if (word_of(a) == word_of(sledc_pkg::ADDR_MOD_FAULT)) begin
      r[FW-1:0] = mod_fault_word;
    end else if (word_of(a) == word_of(sledc_pkg::ADDR_IRQ_STATUS)) begin
      r[sledc_pkg::IRQ_W-1:0] = irq_status;
    end else if (word_of(a) == word_of(sledc_pkg::ADDR_IRQ_MASK)) begin
      r[sledc_pkg::IRQ_W-1:0] = irq_mask;
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (word_of(a) == 6'(word_of(sledc_pkg::ADDR_AXIS_FAULT) + i)) begin
          r[FW-1:0] = axis_fault_word[i];
        end
      end
    end
    return r;
  endfunction : read_word

  // ****************************************************************
  // ahb-lite slave: zero wait states, always okay
  // ****************************************************************
  assign hreadyout      = 1'b1;
  assign hresp          = sledc_pkg::HRESP_OKAY;
  assign ap_valid       = hsel && hready && htrans[1];
  assign ap_read_status = ap_valid && !hwrite &&
                          (word_of(haddr[7:0]) ==
                           word_of(sledc_pkg::ADDR_IRQ_STATUS));

  // address phase capture; write data lands in the next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= ap_valid && hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // read data is registered at the address phase so it stands
  // from a flop for the whole data phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= read_word(haddr[7:0]);
    end
  end

  // control and mask registers; other writes are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl     <= sledc_pkg::CTRL_RESET;
      irq_mask <= sledc_pkg::IRQ_RESET;
    end else if (dp_write) begin
      if (word_of(dp_addr) == word_of(sledc_pkg::ADDR_CTRL)) begin
        ctrl <= hwdata[sledc_pkg::CTRL_W-1:0];
      end
      if (word_of(dp_addr) == word_of(sledc_pkg::ADDR_IRQ_MASK)) begin
        irq_mask <= hwdata[sledc_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // flash slot timing
  // ****************************************************************
  sledc_tick #(
    .TICKS (TICK_CYCLES)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  // one counter feeds every rate, so boot and watchdog patterns
  // keep health and config in a fixed phase relation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= '0;
    end else if (tick) begin
      phase <= phase + 1'b1;
    end
  end

  // ****************************************************************
  // error flags and fault words
  // ****************************************************************
  // clear acts on the off edge of the on-then-off pulse
  assign clear_pulse = clear_prev && !ctrl[sledc_pkg::CTRL_CLEAR_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clear_prev <= 1'b0;
    end else begin
      clear_prev <= ctrl[sledc_pkg::CTRL_CLEAR_BIT];
    end
  end

  // a new report in the clear cycle wins, and a lasting cause
  // blocks the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_err <= 1'b0;
      stop_err   <= 1'b0;
    end else begin
      if (err_report && !err_stop) begin
        status_err <= 1'b1;
      end else if (clear_pulse && !err_persist) begin
        status_err <= 1'b0;
      end
      if (err_report && err_stop) begin
        stop_err <= 1'b1;
      end else if (clear_pulse && !err_persist) begin
        stop_err <= 1'b0;
      end
    end
  end

  assign module_fault = status_err || stop_err;

  // error code goes to the module word (axis 0) or an axis word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_fault_word <= sledc_pkg::FAULT_RESET;
      for (int i = 0; i < AXES; i++) begin
        axis_fault_word[i] <= sledc_pkg::FAULT_RESET;
      end
    end else if (err_report) begin
      if (err_axis == 3'h0) begin
        mod_fault_word <= err_code;
      end
      for (int i = 0; i < AXES; i++) begin
        if (err_axis == 3'(i + 1)) begin
          axis_fault_word[i] <= err_code;
        end
      end
    end
  end

  // ****************************************************************
  // interrupts: sticky, read-clear, masked
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_prev <= 1'b0;
      diag_prev     <= 1'b0;
    end else begin
      watchdog_prev <= watchdog_timeout;
      diag_prev     <= diag_fail;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[sledc_pkg::IRQ_STATUS_ERR] = err_report && !err_stop;
    irq_event[sledc_pkg::IRQ_STOP_ERR]   = err_report && err_stop;
    irq_event[sledc_pkg::IRQ_WATCHDOG]   = watchdog_timeout && !watchdog_prev;
    irq_event[sledc_pkg::IRQ_DIAG_FAIL]  = diag_fail && !diag_prev;
  end

  // an event in the reading cycle survives the read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= sledc_pkg::IRQ_RESET;
    end else if (ap_read_status) begin
      irq_status <= irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************************************
  // power-up code blinker
  // ****************************************************************
  // a zero code shows as no blinks in that half; limitation accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_state  <= sledc_pkg::SLEDC_CODE_IDLE;
      code_slots  <= 6'h00;
      code_left   <= '0;
      code_second <= 1'b0;
    end else if (!diag_fail) begin
      code_state  <= sledc_pkg::SLEDC_CODE_IDLE;
      code_second <= 1'b0;
    end else if (tick) begin
      unique case (code_state)
        sledc_pkg::SLEDC_CODE_IDLE: begin
          code_state  <= sledc_pkg::SLEDC_CODE_OFF;
          code_slots  <= sledc_pkg::CODE_OFF_SLOTS;
          code_left   <= diag_code_first;
          code_second <= 1'b0;
        end
        sledc_pkg::SLEDC_CODE_ON: begin
          if (code_slots == 6'h01) begin
            code_state <= sledc_pkg::SLEDC_CODE_OFF;
            code_slots <= sledc_pkg::CODE_OFF_SLOTS;
          end else begin
            code_slots <= code_slots - 1'b1;
          end
        end
        sledc_pkg::SLEDC_CODE_OFF: begin
          if (code_slots != 6'h01) begin
            code_slots <= code_slots - 1'b1;
          end else if (code_left != '0) begin
            code_state <= sledc_pkg::SLEDC_CODE_ON;
            code_slots <= sledc_pkg::CODE_ON_SLOTS;
            code_left  <= code_left - 1'b1;
          end else if (!code_second) begin
            code_state <= sledc_pkg::SLEDC_CODE_PAUSE;
            code_slots <= sledc_pkg::CODE_PAUSE_SLOTS;
          end else begin
            code_state <= sledc_pkg::SLEDC_CODE_GAP;
            code_slots <= sledc_pkg::CODE_GAP_SLOTS;
          end
        end
        sledc_pkg::SLEDC_CODE_PAUSE: begin
          if (code_slots == 6'h01) begin
            code_state  <= sledc_pkg::SLEDC_CODE_OFF;
            code_slots  <= 6'h01;
            code_left   <= diag_code_second;
            code_second <= 1'b1;
          end else begin
            code_slots <= code_slots - 1'b1;
          end
        end
        sledc_pkg::SLEDC_CODE_GAP: begin
          if (code_slots == 6'h01) begin
            code_state <= sledc_pkg::SLEDC_CODE_IDLE;
          end else begin
            code_slots <= code_slots - 1'b1;
          end
        end
        default: begin
          code_state <= sledc_pkg::SLEDC_CODE_IDLE;
        end
      endcase
    end
  end

  assign code_lamp = (code_state == sledc_pkg::SLEDC_CODE_ON);

  // ****************************************************************
  // indicator selection
  // ****************************************************************
  assign running = powerup_done && !diag_fail;

  // priority: code blink, unfinished start, boot, watchdog, stop, status
  always_comb begin
    next_health = 1'b0;
    next_config = ctrl[sledc_pkg::CTRL_CFG_BIT];
    if (diag_fail) begin
      next_health = code_lamp;
      next_config = 1'b0;
    end else if (!powerup_done) begin
      next_health = 1'b0;
    end else if (boot_mode) begin
      next_health = phase[sledc_pkg::CONST_BIT];
      next_config = phase[sledc_pkg::CONST_BIT];
    end else if (watchdog_timeout) begin
      next_health = phase[sledc_pkg::CONST_BIT];
      next_config = !phase[sledc_pkg::CONST_BIT];
    end else if (stop_err) begin
      next_health = phase[sledc_pkg::FAST_BIT];
    end else if (status_err) begin
      next_health = phase[sledc_pkg::SLOW_BIT];
    end else begin
      next_health = 1'b1;
    end
  end

  // all indicators come from flops, one cycle behind their causes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      health_indicator   <= 1'b0;
      config_indicator   <= 1'b0;
      liveness_indicator <= 1'b0;
    end else begin
      health_indicator   <= next_health;
      config_indicator   <= next_config;
      liveness_indicator <= running;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      axis1_drive_on_indicator <= 1'b0;
      axis2_drive_on_indicator <= 1'b0;
      axis3_drive_on_indicator <= 1'b0;
      axis4_drive_on_indicator <= 1'b0;
    end else begin
      axis1_drive_on_indicator <= drive_relay_on[0];
      axis2_drive_on_indicator <= drive_relay_on[1];
      axis3_drive_on_indicator <= drive_relay_on[2];
      axis4_drive_on_indicator <= drive_relay_on[3];
    end
  end

endmodule : sledc_top

`default_nettype wire

// ===== sim/sledc_top_properties.sv
// checker for the status indicator block, bound to sledc_top
// assumes one hclk domain and registered, lagging lamps
`timescale 1ns/10ps
`default_nettype none
module sledc_top_properties #(
  parameter int AXES = sledc_pkg::AXES
) (
  // clock and reset
  input wire logic            hclk,
  input wire logic            hresetn,
  // mode and error inputs
  input wire logic            powerup_done,
  input wire logic            diag_fail,
  input wire logic            boot_mode,
  input wire logic            watchdog_timeout,
  input wire logic            err_report,
  input wire logic            err_persist,
  input wire logic [AXES-1:0] drive_relay_on,
  // lamps and flags
  input wire logic            health_indicator,
  input wire logic            liveness_indicator,
  input wire logic            config_indicator,
  input wire logic            axis1_drive_on_indicator,
  input wire logic            axis2_drive_on_indicator,
  input wire logic            axis3_drive_on_indicator,
  input wire logic            axis4_drive_on_indicator,
  input wire logic            module_fault
);
  // ****************************************************************
  // lamp relations
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // lamps are registered: causes are seen one edge back
  sequence up_run;
    $past(hresetn) && $past(powerup_done) && !$past(diag_fail);
  endsequence
  sequence boot_seen;
    up_run ##0 $past(boot_mode);
  endsequence
  sequence wdog_seen;
    up_run ##0 ($past(watchdog_timeout) && !$past(boot_mode));
  endsequence
  a_axis_lamps_follow: assert property (
    $past(hresetn) |-> {axis4_drive_on_indicator, axis3_drive_on_indicator,
    axis2_drive_on_indicator, axis1_drive_on_indicator} ==
    $past(drive_relay_on[3:0])) else $error("axis lamp differs from relay");
  a_live_lamp: assert property (
    $past(hresetn) |-> liveness_indicator ==
    ($past(powerup_done) && !$past(diag_fail))) else $error("liveness wrong");
  a_dark_unpowered: assert property (
    $past(hresetn) && !$past(powerup_done) && !$past(diag_fail) |->
    !health_indicator) else $error("health lit before power-up");
  a_config_dark_diag: assert property (
    $past(hresetn) && $past(diag_fail) |-> !config_indicator)
    else $error("config lit during diagnostic failure");
  a_boot_together: assert property (
    boot_seen |-> health_indicator == config_indicator)
    else $error("boot lamps out of phase");
  a_wdog_apart: assert property (
    wdog_seen |-> health_indicator != config_indicator)
    else $error("watchdog lamps in phase");
  a_fault_set: assert property (
    err_report |=> module_fault) else $error("fault flag not set");
  a_fault_held: assert property (
    err_persist && module_fault |=> module_fault)
    else $error("fault cleared while cause persists");
endmodule : sledc_top_properties
bind sledc_top sledc_top_properties #(.AXES(AXES)) i_sledc_top_properties (
  .hclk, .hresetn, .powerup_done, .diag_fail, .boot_mode, .watchdog_timeout,
  .err_report, .err_persist, .drive_relay_on, .health_indicator,
  .liveness_indicator, .config_indicator, .axis1_drive_on_indicator,
  .axis2_drive_on_indicator, .axis3_drive_on_indicator,
  .axis4_drive_on_indicator, .module_fault);
`default_nettype wire

// ===== sim/sledc_led_watch.sv
// operator's eye on one lamp: cycles between its last two changes
// assumes the lamp is a registered output of the hclk domain
`timescale 1ns/10ps
`default_nettype none
module sledc_led_watch (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // lamp seen and last span
  input  wire logic       lamp,
  output logic      [7:0] gap
);
  logic       seen;
  logic [7:0] run;
  // a change closes a span; run stops at 255, so spans of 256 cycles or more read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen <= 1'b0;
      run  <= 8'h00;
      gap  <= 8'h00;
    end else if (lamp != seen) begin
      seen <= lamp;
      gap  <= run + 8'h01;
      run  <= 8'h00;
    end else if (run != 8'hff) begin
      run <= run + 8'h01;
    end
  end
endmodule : sledc_led_watch
`default_nettype wire

// ===== sim/sledc_top_tb.sv
// self-checking bench: ahb-lite master, error, mode and lamp runs
// assumes the slot is shortened to four clocks
`timescale 1ns/10ps
`default_nettype none
module sledc_top_tb;
  localparam int TK = 4;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, err_axis, ax;
  logic        powerup_done, diag_fail, boot_mode, watchdog_timeout;
  logic        err_report, err_stop, err_persist, health, live, cfg, fault, irq;
  logic [3:0]  relay, lamps;
  logic [15:0] code;
  logic [7:0]  gap;
  int          failures, checked, seed;
  sledc_top #(.TICK_CYCLES(TK)) i_sledc_top (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .powerup_done, .diag_fail,
    .diag_code_first(code[3:0] | 4'h1), .diag_code_second(code[7:4]),
    .boot_mode, .watchdog_timeout, .err_report, .err_stop, .err_axis,
    .err_code(code), .err_persist, .drive_relay_on(relay),
    .health_indicator(health), .liveness_indicator(live),
    .config_indicator(cfg),
    .axis1_drive_on_indicator(lamps[0]), .axis2_drive_on_indicator(lamps[1]),
    .axis3_drive_on_indicator(lamps[2]), .axis4_drive_on_indicator(lamps[3]),
    .module_fault(fault), .irq);
  sledc_led_watch i_sledc_led_watch (.hclk, .hresetn, .lamp(health), .gap);
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  function automatic logic [7:0] egap(input int slots);
    return 8'(slots * TK);
  endfunction : egap
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // single transfer; each phase holds until hready is seen
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= sledc_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic err(input logic stop, input logic [2:0] axis);
    @(posedge hclk);
    err_report <= 1'b1;
    err_stop   <= stop;
    err_axis   <= axis;
    code       <= 16'($random(seed));
    @(posedge hclk);
    err_report <= 1'b0;
  endtask : err
  task automatic clr;
    bus(1'b1, sledc_pkg::ADDR_CTRL, 32'h3);
    bus(1'b1, sledc_pkg::ADDR_CTRL, 32'h1);
    repeat (4) @(posedge hclk);
  endtask : clr
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    #(50 * 20000);
    failures++;
    final_report;
  end
  initial begin
    seed = 60653; failures = 0; checked = 0; hresetn = 1'b0; hsel = 1'b0;
    haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 0;
    powerup_done = 0; diag_fail = 0; boot_mode = 0; watchdog_timeout = 0;
    err_report = 0; err_stop = 0; err_axis = 0; code = 0; err_persist = 0;
    relay = 4'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({health, live}, 2'b00);
    powerup_done <= 1'b1;
    bus(1'b1, sledc_pkg::ADDR_CTRL, 32'h1);
    repeat (20) @(posedge hclk);
    chk({health, live, cfg}, 3'b111);
    repeat (8) begin
      relay <= 4'($random(seed));
      repeat (2) @(posedge hclk);
      chk(lamps, relay);
    end
    bus(1'b1, sledc_pkg::ADDR_IRQ_MASK, 32'h3);
    err(1'b0, 3'h0);
    repeat (40) @(posedge hclk);
    chk({fault, irq, gap}, {2'b11, egap(2)});
    bus(1'b0, sledc_pkg::ADDR_MOD_FAULT, 0);
    chk(rd, {16'h0, code});
    bus(1'b0, sledc_pkg::ADDR_IRQ_STATUS, 0);
    repeat (3) @(posedge hclk);
    chk({rd[3:0], irq, hresp}, 6'b000100);
    ax = 3'($unsigned($random(seed)) % 4 + 1);
    err(1'b1, ax);
    repeat (40) @(posedge hclk);
    chk(gap, egap(1));
    bus(1'b0, sledc_pkg::ADDR_AXIS_FAULT + 8'(4 * (ax - 1)), 0);
    chk(rd, {16'h0, code});
    err_persist <= 1'b1;
    clr;
    chk(fault, 1'b1);
    err_persist <= 1'b0;
    clr;
    repeat (30) @(posedge hclk);
    chk({fault, health}, 2'b01);
    boot_mode <= 1'b1;
    repeat (80) @(posedge hclk);
    chk({gap, health}, {egap(4), cfg});
    boot_mode <= 1'b0;
    watchdog_timeout <= 1'b1;
    repeat (80) @(posedge hclk);
    chk({gap, health}, {egap(4), !cfg});
    watchdog_timeout <= 1'b0;
    diag_fail <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({cfg, live}, 2'b00);
    for (int i = 0; i < 400 && health !== 1'b1; i++) @(posedge hclk);
    for (int i = 0; i < 400 && health !== 1'b0; i++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    chk(gap, egap(4));
    bus(1'b0, 8'h40, 0);
    chk(rd, 32'h0);
    final_report;
  end
endmodule : sledc_top_tb
`default_nettype wire
